// ==== verilog/sspm_pkg.sv ====
// Constants and types for the scratchpad, stack and program-space map block.
// Assumes a single clock domain and a core that issues one access per cycle.
package sspm_pkg;
	// Special-function register addresses held by this block
	localparam logic [7:0] SSPM_SFR_STACK_TOP = 8'h81;
	localparam logic [7:0] SSPM_SFR_STATUS_WORD = 8'hD0;
	// Reset values
	localparam logic [7:0] SSPM_STACK_TOP_RESET = 8'h07;
	localparam logic [7:0] SSPM_STATUS_WORD_RESET = 8'h00;
	localparam logic [15:0] SSPM_RESET_PC = 16'h0000;
	// Bank select field inside the status word
	localparam int SSPM_BANK_HI = 4;
	localparam int SSPM_BANK_LO = 3;
	// Bit-addressable scratchpad bytes start here, direct space splits here
	localparam logic [7:0] SSPM_BIT_RAM_BASE = 8'h20;
	localparam logic [7:0] SSPM_SFR_BASE = 8'h80;
	// Internal program memory size in bytes: one of 4k, 8k, 16k or 32k per variant
	localparam logic [16:0] SSPM_PROG_BYTES = 17'h0_8000;
	// Boot ROM placement
	localparam logic [15:0] SSPM_BOOT_USER_BASE = 16'hF800;
	localparam logic [15:0] SSPM_BOOT_PROG_TOP = 16'h0800;
	// Fixed boot routine entry points
	localparam logic [15:0] SSPM_ENTRY_PAGE_ERASE = 16'hFFD7;
	localparam logic [15:0] SSPM_ENTRY_BYTE_WRITE = 16'hFFDD;
	localparam logic [7:0] SSPM_ONE = 8'h01;
	localparam logic [7:0] SSPM_TWO = 8'h02;

	// Access kinds issued by the core
	typedef enum logic [3:0] {
		SSPM_OP_NOP, SSPM_OP_DIR_RD, SSPM_OP_DIR_WR, SSPM_OP_IND_RD, SSPM_OP_IND_WR,
		SSPM_OP_BIT_RD, SSPM_OP_BIT_WR, SSPM_OP_REG_RD, SSPM_OP_REG_WR,
		SSPM_OP_PUSH, SSPM_OP_POP, SSPM_OP_CALL, SSPM_OP_RET
	} sspm_op_e;

	// Where a program fetch is served from
	typedef enum logic [1:0] {
		SSPM_FETCH_INT, SSPM_FETCH_EXT, SSPM_FETCH_BOOT
	} sspm_fetch_e;
endpackage

// ==== verilog/sspm_core.sv ====
// Scratchpad RAM, working-register banks, stack and program fetch steering.
// Assumes the core issues at most one op per cycle with inputs synchronous to mclk_i.
//
// Function
// [RULE1] Scratchpad bytes 20h-2Fh give 128 bits
// [RULE2] Bit access only to SFRs ending 0/8
// [RULE3] Instruction type picks bit or byte access
// [RULE4] Four banks of eight registers, selected bank used
// [RULE5] Bank chosen by status word at D0h
// [RULE6] Registers zero/one act as indirect pointers
// [RULE7] Calls and interrupts push return address; the code pushes only on SSPM_OP_CALL and has no interrupt input
// [RULE8] Stack pointer at 81h resets to 07h
// [RULE9] Next stack write goes to pointer plus one
// [RULE10] Push/call raise pointer, pop/return lower it
// [RULE11] Fetching starts at address 0000h after reset
// [RULE12] Select high: internal, external beyond range
// [RULE13] Select low: every fetch is external; the code still sends fetches in a boot ROM window to the boot ROM
// [RULE14] Internal size per variant bounds internal range
// [RULE15] User mode boot ROM at F800h-FFFFh
// [RULE16] Programming mode boot ROM at lowest 2kB
// [RULE17] Boot ROM has fixed routine entry points
// [RULE18] Direct 80h-FFh means SFRs, upper RAM indirect
// [RULE19] Stack pointer is 8 bits, wraps mod 256
`timescale 1ns/100ps
module sspm_core import sspm_pkg::*; (
	input wire logic mclk_i, // 25 MHz system clock
	input wire logic resetn_i, // Synchronous reset, active low
	input wire sspm_op_e op_i, // Access kind for this cycle
	input wire logic [7:0] addr_i, // Direct, bit or indirect-less address
	input wire logic [2:0] reg_idx_i, // Working register number
	input wire logic [7:0] wdata_i, // Write byte, bit value in bit 0
	input wire logic [15:0] ret_addr_i, // Return address for a call
	input wire logic external_fetch_select_i, // Sampled during reset
	input wire logic prog_mode_i, // High in programming mode
	input wire logic boot_enable_i, // Boot ROM visible in user mode
	input wire logic fetch_req_i, // Fetch steering request
	input wire logic [15:0] pc_i, // Fetch address
	output logic [7:0] rdata_o, // Read byte, bit results in bit 0
	output logic rdata_valid_o, // One-cycle pulse with rdata_o, or with ret_addr_o on a return
	output logic [15:0] ret_addr_o, // Address popped by a return
	output logic [7:0] stack_top_pointer_o, // Current stack pointer
	output logic [7:0] processor_status_word_o, // Current status word
	output logic [15:0] start_pc_o, // Fetch start address
	output logic fetch_valid_o, // One-cycle pulse with fetch result
	output sspm_fetch_e fetch_target_o, // Memory serving the fetch
	output logic [15:0] fetch_offset_o, // Address within that memory
	output logic boot_entry_o // Fetch hits a known boot routine
);
	// Whole block state; the RAM is a packed array so it lives in the struct
	typedef struct packed {
		logic [255:0][7:0] ram; // 256-byte scratchpad
		logic [7:0] sp; // Stack pointer
		logic [7:0] processor_status_word; // Status word
		logic [7:0] rdata; // Registered read result
		logic rvalid; // Read result pulse
		logic [15:0] ret_addr; // Popped return address
		logic ea_hi; // Fetch select level caught at reset
		logic [15:0] start_pc; // Reset vector
		logic fvalid; // Fetch result pulse
		sspm_fetch_e ftarget; // Fetch destination
		logic [15:0] foffset; // Fetch address in destination
		logic fentry; // Boot entry hit
	} sspm_state_s;

	sspm_state_s s_reg;
	sspm_state_s s_next;

	// Direct read: low half is RAM, upper half is SFR space only
	function automatic logic [7:0] sspm_dir_rd(sspm_state_s st, logic [7:0] a);
		if (a < SSPM_SFR_BASE) begin
			return st.ram[a];
		end else if (a == SSPM_SFR_STACK_TOP) begin
			return st.sp;
		end else if (a == SSPM_SFR_STATUS_WORD) begin
			return st.processor_status_word;
		end else begin
			// SFRs owned elsewhere read as zero here
			return 8'h00;
		end
	endfunction

	// Direct write, same split as the read
	function automatic sspm_state_s sspm_dir_wr(sspm_state_s st, logic [7:0] a,
			logic [7:0] d);
		sspm_state_s r;
		r = st;
		if (a < SSPM_SFR_BASE) begin
			r.ram[a] = d; // RULE18
		end else if (a == SSPM_SFR_STACK_TOP) begin
			r.sp = d; // RULE8
		end else if (a == SSPM_SFR_STATUS_WORD) begin
			r.processor_status_word = d; // RULE5
		end
		return r;
	endfunction

	// Next-state logic for accesses and fetch steering
	always_comb begin
		logic [7:0] bank_base;
		logic [7:0] reg_addr;
		logic [7:0] ptr;
		logic [7:0] bit_byte;
		logic [7:0] cur;
		logic [7:0] sp_p1;
		logic [7:0] sp_p2;
		logic [7:0] sp_m1;
		logic [7:0] sp_m2;
		logic in_boot_user;
		logic in_boot_prog;
		// Defined on every path before the address split below picks the real byte
		bit_byte = 8'h00;
		s_next = s_reg;
		// Working registers of the selected bank sit at bank*8
		bank_base = {3'b000, s_reg.processor_status_word[SSPM_BANK_HI:SSPM_BANK_LO], 3'b000}; // RULE5
		reg_addr = bank_base | {5'b00000, reg_idx_i}; // RULE4
		// Pointer comes from register zero or one of that bank
		ptr = s_reg.ram[bank_base | {7'b0000000, reg_idx_i[0]}]; // RULE6
		// Bit number: low half maps into 20h-2Fh, high half into SFRs at x0/x8
		if (addr_i[7]) begin
			bit_byte = {addr_i[7:3], 3'b000}; // RULE2
		end else begin
			bit_byte = 8'(SSPM_BIT_RAM_BASE + {4'b0000, addr_i[6:3]}); // RULE1
		end
		cur = sspm_dir_rd(s_reg, bit_byte);
		// Stack pointer arithmetic wraps in eight bits
		sp_p1 = 8'(s_reg.sp + SSPM_ONE); // RULE19
		sp_p2 = 8'(s_reg.sp + SSPM_TWO);
		sp_m1 = 8'(s_reg.sp - SSPM_ONE);
		sp_m2 = 8'(s_reg.sp - SSPM_TWO);
		s_next.rvalid = 1'b0;
		// The op, not the address, decides bit versus byte handling
		case (op_i) // RULE3
			SSPM_OP_DIR_RD: begin
				s_next.rdata = sspm_dir_rd(s_reg, addr_i); // RULE18
				s_next.rvalid = 1'b1;
			end
			SSPM_OP_DIR_WR: begin
				// Built on s_next so the cleared read pulse is not copied back from s_reg
				s_next = sspm_dir_wr(s_next, addr_i, wdata_i);
			end
			SSPM_OP_IND_RD: begin
				// Indirect reaches all 256 bytes, including the upper half
				s_next.rdata = s_reg.ram[ptr]; // RULE6
				s_next.rvalid = 1'b1;
			end
			SSPM_OP_IND_WR: begin
				s_next.ram[ptr] = wdata_i; // RULE6
			end
			SSPM_OP_BIT_RD: begin
				s_next.rdata = {7'b0000000, cur[addr_i[2:0]]}; // RULE1
				s_next.rvalid = 1'b1;
			end
			SSPM_OP_BIT_WR: begin
				// Read-modify-write of the owning byte
				cur[addr_i[2:0]] = wdata_i[0];
				s_next = sspm_dir_wr(s_next, bit_byte, cur); // RULE2
			end
			SSPM_OP_REG_RD: begin
				s_next.rdata = s_reg.ram[reg_addr]; // RULE4
				s_next.rvalid = 1'b1;
			end
			SSPM_OP_REG_WR: begin
				s_next.ram[reg_addr] = wdata_i; // RULE4
			end
			SSPM_OP_PUSH: begin
				s_next.ram[sp_p1] = wdata_i; // RULE9
				s_next.sp = sp_p1; // RULE10
			end
			SSPM_OP_POP: begin
				s_next.rdata = s_reg.ram[s_reg.sp];
				s_next.rvalid = 1'b1;
				s_next.sp = sp_m1; // RULE10
			end
			SSPM_OP_CALL: begin
				// Low byte first, high byte on top, as a return expects
				s_next.ram[sp_p1] = ret_addr_i[7:0]; // RULE7
				s_next.ram[sp_p2] = ret_addr_i[15:8]; // RULE9
				s_next.sp = sp_p2; // RULE10
			end
			SSPM_OP_RET: begin
				s_next.ret_addr = {s_reg.ram[s_reg.sp], s_reg.ram[sp_m1]};
				s_next.rvalid = 1'b1;
				s_next.sp = sp_m2; // RULE10
			end
			default: begin
				s_next.rvalid = 1'b0;
			end
		endcase
		// Fetch steering; boot ROM windows take priority over flash decode
		in_boot_user = !prog_mode_i && boot_enable_i && (pc_i >= SSPM_BOOT_USER_BASE);
		in_boot_prog = prog_mode_i && (pc_i < SSPM_BOOT_PROG_TOP);
		s_next.fvalid = fetch_req_i;
		s_next.fentry = 1'b0;
		if (in_boot_user || in_boot_prog) begin
			s_next.ftarget = SSPM_FETCH_BOOT; // RULE15
			s_next.foffset = {5'b00000, pc_i[10:0]}; // RULE16
			// Entry points only mean something where the ROM sits at the top
			s_next.fentry = in_boot_user && ((pc_i == SSPM_ENTRY_PAGE_ERASE) ||
				(pc_i == SSPM_ENTRY_BYTE_WRITE)); // RULE17
		end else if (!s_reg.ea_hi) begin
			s_next.ftarget = SSPM_FETCH_EXT; // RULE13
			s_next.foffset = pc_i;
		end else if ({1'b0, pc_i} < SSPM_PROG_BYTES) begin
			s_next.ftarget = SSPM_FETCH_INT; // RULE14
			s_next.foffset = pc_i;
		end else begin
			s_next.ftarget = SSPM_FETCH_EXT; // RULE12
			s_next.foffset = pc_i;
		end
	end

	// State register; the fetch select pin is caught while reset is held
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			s_reg <= '0;
			s_reg.sp <= SSPM_STACK_TOP_RESET; // RULE8
			s_reg.processor_status_word <= SSPM_STATUS_WORD_RESET;
			s_reg.start_pc <= SSPM_RESET_PC; // RULE11
			s_reg.ea_hi <= external_fetch_select_i; // RULE13
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register
	assign rdata_o = s_reg.rdata;
	assign rdata_valid_o = s_reg.rvalid;
	assign ret_addr_o = s_reg.ret_addr;
	assign stack_top_pointer_o = s_reg.sp;
	assign processor_status_word_o = s_reg.processor_status_word;
	assign start_pc_o = s_reg.start_pc;
	assign fetch_valid_o = s_reg.fvalid;
	assign fetch_target_o = s_reg.ftarget;
	assign fetch_offset_o = s_reg.foffset;
	assign boot_entry_o = s_reg.fentry;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_push_req;
		op_i == SSPM_OP_PUSH;
	endsequence
	sequence s_user_boot_fetch;
		fetch_req_i && !prog_mode_i && boot_enable_i && pc_i >= SSPM_BOOT_USER_BASE;
	endsequence

	property p_sp_reset;
		$rose(resetn_i) |-> stack_top_pointer_o == SSPM_STACK_TOP_RESET && start_pc_o == 16'h0000;
	endproperty
	a_sp_reset: assert property (p_sp_reset) else $error("bad reset state"); // RULE8
	property p_push;
		s_push_req |=> stack_top_pointer_o == 8'($past(s_reg.sp) + 8'h01) &&
			s_reg.ram[stack_top_pointer_o] == $past(wdata_i);
	endproperty
	a_push: assert property (p_push) else $error("push wrong"); // RULE9
	property p_call;
		op_i == SSPM_OP_CALL |=> stack_top_pointer_o == 8'($past(s_reg.sp) + 8'h02) &&
			s_reg.ram[stack_top_pointer_o] == $past(ret_addr_i[15:8]);
	endproperty
	a_call: assert property (p_call) else $error("call wrong"); // RULE7
	property p_call_ret;
		op_i == SSPM_OP_CALL ##1 op_i == SSPM_OP_RET |=>
			ret_addr_o == $past(ret_addr_i, 2) && rdata_valid_o;
	endproperty
	a_call_ret: assert property (p_call_ret) else $error("return mismatch"); // RULE10
	property p_pop;
		op_i == SSPM_OP_POP |=> stack_top_pointer_o == 8'($past(s_reg.sp) - 8'h01) &&
			rdata_valid_o;
	endproperty
	a_pop: assert property (p_pop) else $error("pop wrong"); // RULE10
	property p_wrap;
		s_push_req and stack_top_pointer_o == 8'hFF |=> stack_top_pointer_o == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap"); // RULE19
	property p_bank;
		op_i == SSPM_OP_REG_WR |=> s_reg.ram[{3'b000, $past(s_reg.processor_status_word[4:3]),
			$past(reg_idx_i)}] == $past(wdata_i);
	endproperty
	a_bank: assert property (p_bank) else $error("bank write wrong"); // RULE4
	property p_sfr_bit;
		op_i == SSPM_OP_BIT_WR && addr_i == 8'hD3 |=>
			processor_status_word_o[3] == $past(wdata_i[0]);
	endproperty
	a_sfr_bit: assert property (p_sfr_bit) else $error("status bit write"); // RULE2
	property p_ext_low;
		fetch_req_i && !s_reg.ea_hi && !prog_mode_i && !boot_enable_i |=>
			fetch_target_o == SSPM_FETCH_EXT;
	endproperty
	a_ext_low: assert property (p_ext_low) else $error("fetch not external"); // RULE13
	property p_int_hi;
		fetch_req_i && s_reg.ea_hi && !prog_mode_i && {1'b0, pc_i} < SSPM_PROG_BYTES |=>
			fetch_target_o == SSPM_FETCH_INT;
	endproperty
	a_int_hi: assert property (p_int_hi) else $error("fetch not internal"); // RULE12
	property p_boot_user;
		s_user_boot_fetch |=> fetch_target_o == SSPM_FETCH_BOOT &&
			fetch_offset_o == {5'b00000, $past(pc_i[10:0])};
	endproperty
	a_boot_user: assert property (p_boot_user) else $error("user boot map"); // RULE15
	property p_boot_prog;
		fetch_req_i && prog_mode_i && pc_i < 16'h0800 |=> fetch_target_o == SSPM_FETCH_BOOT;
	endproperty
	a_boot_prog: assert property (p_boot_prog) else $error("prog boot map"); // RULE16
	property p_entry;
		s_user_boot_fetch and pc_i == 16'hFFD7 |=> boot_entry_o && fetch_valid_o;
	endproperty
	a_entry: assert property (p_entry) else $error("entry missed"); // RULE17
endmodule

// ==== bench/sspm_cpu.sv ====
// Core-side model: issues access ops and fetch requests into the block.
// Assumes its tasks are called at a falling edge of mclk_i; each returns at a falling edge.
`timescale 1ns/100ps
module sspm_cpu import sspm_pkg::*; (
	input wire logic mclk_i, // System clock
	output sspm_op_e op_o, // Access kind
	output logic [7:0] addr_o, // Direct or bit address
	output logic [2:0] reg_idx_o, // Working register number
	output logic [7:0] wdata_o, // Write byte
	output logic [15:0] ret_addr_o, // Return address for a call
	output logic fetch_req_o, // Fetch request
	output logic [15:0] pc_o // Fetch address
);
	// Idle from time zero so the block never samples unknowns
	initial begin
		op_o = SSPM_OP_NOP;
		addr_o = 8'h00;
		reg_idx_o = 3'h0;
		wdata_o = 8'h00;
		ret_addr_o = 16'h0000;
		fetch_req_o = 1'b0;
		pc_o = 16'h0000;
	end
	// One op, taken at the next rising edge and left driven until the next task; back to back calls are legal
	task automatic do_access(input sspm_op_e op, input logic [7:0] a, input logic [2:0] r,
		input logic [7:0] d, input logic [15:0] ra);
		op_o = op;
		addr_o = a;
		reg_idx_o = r;
		wdata_o = d;
		ret_addr_o = ra;
		@(negedge mclk_i);
	endtask
	// One fetch request, taken at the next rising edge
	task automatic fetch(input logic [15:0] pc);
		fetch_req_o = 1'b1;
		pc_o = pc;
		@(negedge mclk_i);
	endtask
	// Drop requests; address, write data and fetch address lines flip so stale values are never trusted
	task automatic idle();
		op_o = SSPM_OP_NOP;
		fetch_req_o = 1'b0;
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
		pc_o = ~pc_o;
		@(negedge mclk_i);
	endtask
endmodule

// ==== bench/tb.sv ====
// Self-checking bench: an integer model of scratchpad, stack and fetch map.
// Assumes one-cycle answers on both ports, as the block's hand-over describes.
`timescale 1ns/100ps
module tb import sspm_pkg::*;;
	logic mclk_i = 1'b0; // 25 MHz clock
	logic resetn_i = 1'b0; // Reset, active low
	logic ext_sel = 1'b1; // Fetch select, captured in reset
	logic prog = 1'b0; // Programming mode
	logic boot_en = 1'b0; // Boot ROM visible in user mode
	sspm_op_e op;
	logic [7:0] addr, wdata, rdata, sp_q, psw_q;
	logic [2:0] ridx;
	logic [15:0] ra_in, pc, ra_out, start_pc, foff;
	logic fetch_req, rvalid, fvalid, bentry;
	sspm_fetch_e ftgt;
	int ram[256]; // Model scratchpad
	int sp, processor_status_word; // Model pointer and status word
	int mismatches = 0;
	int tests_run = 0;
	// Clock
	always #20 mclk_i = ~mclk_i;
	sspm_cpu i_sspm_cpu (.mclk_i(mclk_i), .op_o(op), .addr_o(addr), .reg_idx_o(ridx),
		.wdata_o(wdata), .ret_addr_o(ra_in), .fetch_req_o(fetch_req), .pc_o(pc));
	sspm_core i_sspm_core (.mclk_i(mclk_i), .resetn_i(resetn_i), .op_i(op), .addr_i(addr),
		.reg_idx_i(ridx), .wdata_i(wdata), .ret_addr_i(ra_in),
		.external_fetch_select_i(ext_sel), .prog_mode_i(prog), .boot_enable_i(boot_en),
		.fetch_req_i(fetch_req), .pc_i(pc), .rdata_o(rdata), .rdata_valid_o(rvalid),
		.ret_addr_o(ra_out), .stack_top_pointer_o(sp_q), .processor_status_word_o(psw_q),
		.start_pc_o(start_pc), .fetch_valid_o(fvalid), .fetch_target_o(ftgt),
		.fetch_offset_o(foff), .boot_entry_o(bentry));
	// Compare; case inequality so an unknown never passes
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Verdict and end of run
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Requests dropped first, else a held op would be taken as reset ends
	task automatic do_reset(input logic s);
		i_sspm_cpu.idle();
		ext_sel = s;
		resetn_i = 1'b0;
		repeat (8) @(negedge mclk_i);
		resetn_i = 1'b1;
		sp = 7;
		processor_status_word = 0;
		foreach (ram[i]) ram[i] = 0;
		chk("stack_top_pointer", 16'h0007, 16'(sp_q));
		chk("processor_status_word", 16'h0000, 16'(psw_q));
		chk("start_pc", SSPM_RESET_PC, start_pc);
		chk("rdata_valid", 16'h0000, 16'(rvalid));
		chk("fetch_valid", 16'h0000, 16'(fvalid));
	endtask
	// Model one op, issue it, compare every result
	task automatic step(input sspm_op_e o, input logic [7:0] a, input logic [2:0] r,
		input logic [7:0] d, input logic [15:0] ra);
		int rd, byt, b, eret, base, ptr;
		rd = -1;
		eret = 0;
		base = ((processor_status_word >> SSPM_BANK_LO) & 3) * 8;
		byt = a[7] ? {a[7:3], 3'b000} : 32 + a[6:3];
		b = a[2:0];
		ptr = ram[base + r[0]];
		case (o)
			SSPM_OP_DIR_RD: rd = a < 128 ? ram[a] : a == 8'h81 ? sp : a == 8'hD0 ? processor_status_word : 0;
			SSPM_OP_DIR_WR: begin
				if (a < 128) ram[a] = d;
				if (a == SSPM_SFR_STACK_TOP) sp = d;
				if (a == SSPM_SFR_STATUS_WORD) processor_status_word = d;
			end
			SSPM_OP_IND_RD: rd = ram[ptr];
			SSPM_OP_IND_WR: ram[ptr] = d;
			SSPM_OP_BIT_RD: rd = ((a[7] ? (byt == 208 ? processor_status_word : 0) : ram[byt]) >> b) & 1;
			SSPM_OP_BIT_WR: begin
				if (!a[7]) ram[byt] = ram[byt] & ~(1 << b) | (int'(d[0]) << b);
				if (byt == 208) processor_status_word = processor_status_word & ~(1 << b) | (int'(d[0]) << b);
			end
			SSPM_OP_REG_RD: rd = ram[base + r];
			SSPM_OP_REG_WR: ram[base + r] = d;
			SSPM_OP_PUSH: begin
				sp = (sp + 1) % 256;
				ram[sp] = d;
			end
			SSPM_OP_POP: begin
				rd = ram[sp];
				sp = (sp + 255) % 256;
			end
			SSPM_OP_CALL: begin
				ram[(sp + 1) % 256] = ra[7:0];
				ram[(sp + 2) % 256] = ra[15:8];
				sp = (sp + 2) % 256;
			end
			SSPM_OP_RET: begin
				eret = ram[sp] * 256 + ram[(sp + 255) % 256];
				rd = -2;
				sp = (sp + 254) % 256;
			end
			default: rd = -1;
		endcase
		i_sspm_cpu.do_access(o, a, r, d, ra);
		chk("rdata_valid", 16'(rd != -1), 16'(rvalid));
		if (rd >= 0) chk("rdata", 16'(rd), 16'(rdata));
		chk("stack_top_pointer", 16'(sp), 16'(sp_q));
		chk("processor_status_word", 16'(processor_status_word), 16'(psw_q));
		if (o == SSPM_OP_RET) chk("ret_addr", 16'(eret), ra_out);
	endtask
	// Model one fetch and compare its steering
	task automatic fetch_chk(input logic [15:0] p);
		logic boot;
		sspm_fetch_e t;
		boot = prog ? p < SSPM_BOOT_PROG_TOP : boot_en && p >= SSPM_BOOT_USER_BASE;
		t = (!ext_sel || 17'(p) >= SSPM_PROG_BYTES) ? SSPM_FETCH_EXT : SSPM_FETCH_INT;
		if (boot) t = SSPM_FETCH_BOOT;
		i_sspm_cpu.fetch(p);
		chk("fetch_valid", 16'h0001, 16'(fvalid));
		chk("fetch_target", 16'(t), 16'(ftgt));
		chk("fetch_offset", boot ? 16'(p[10:0]) : p, foff);
		chk("boot_entry", 16'(!prog && boot && (p == SSPM_ENTRY_PAGE_ERASE ||
			p == SSPM_ENTRY_BYTE_WRITE)), 16'(bentry));
	endtask
	// Main sequence
	initial begin
		logic [7:0] a;
		void'($urandom(88982));
		do_reset(1'b1);
		step(SSPM_OP_PUSH, 8'h00, 3'h0, 8'h55, 16'h0000);
		step(SSPM_OP_POP, 8'h00, 3'h0, 8'h00, 16'h0000);
		step(SSPM_OP_DIR_WR, SSPM_SFR_STACK_TOP, 3'h0, 8'hFF, 16'h0000);
		step(SSPM_OP_CALL, 8'h00, 3'h0, 8'h00, 16'hA55A);
		step(SSPM_OP_RET, 8'h00, 3'h0, 8'h00, 16'h0000);
		// Pointer now sits at FFh, so this push must wrap to 00h
		step(SSPM_OP_PUSH, 8'h00, 3'h0, 8'hC3, 16'h0000);
		// Single bit of the status word selects bank one, then a register lands there
		step(SSPM_OP_BIT_WR, 8'hD3, 3'h0, 8'h01, 16'h0000);
		step(SSPM_OP_REG_WR, 8'h00, 3'h5, 8'h3C, 16'h0000);
		step(SSPM_OP_REG_RD, 8'h00, 3'h5, 8'h00, 16'h0000);
		for (int n = 0; n < 500; n++) begin
			a = 8'($urandom_range(0, 255));
			case ($urandom_range(0, 5))
				0: a = SSPM_SFR_STACK_TOP;
				1: a = SSPM_SFR_STATUS_WORD;
				2: a = SSPM_SFR_STATUS_WORD | 8'($urandom_range(0, 7));
				default: a = a;
			endcase
			step(sspm_op_e'($urandom_range(1, 12)), a, 3'($urandom), 8'($urandom),
				16'($urandom));
		end
		for (int s = 0; s < 2; s++) begin
			do_reset(s == 0);
			for (int n = 0; n < 150; n++) begin
				prog = $urandom_range(0, 3) == 0;
				boot_en = 1'($urandom);
				case ($urandom_range(0, 4))
					0: fetch_chk(SSPM_ENTRY_PAGE_ERASE);
					1: fetch_chk(SSPM_ENTRY_BYTE_WRITE);
					2: fetch_chk(16'($urandom_range(0, 4095)));
					3: fetch_chk(16'h7FFF + 16'($urandom_range(0, 1)));
					default: fetch_chk(16'($urandom));
				endcase
			end
		end
		i_sspm_cpu.idle();
		// With no request taken the fetch pulse must have fallen
		chk("fetch_valid", 16'h0000, 16'(fvalid));
		end_of_test();
	end
	// Hang guard
	initial begin
		repeat (50000) @(posedge mclk_i);
		mismatches++;
		end_of_test();
	end
endmodule
